// File: rtl/nfc_regs.vh
`ifndef NFC_REGS_VH
`define NFC_REGS_VH
// ==========================================
// Clock and timing figures
`define NFC_CLK_PERIOD_NS   10
// Strobe low width and recovery, ns
`define NFC_WR_PULSE_NS     35
`define NFC_WR_RECOV_NS     20
// Access times, ns
`define NFC_ADDR_ACCESS_NS  70
`define NFC_SEL_ACCESS_NS   70
`define NFC_OE_ACCESS_NS    30
// Reset pulse minimum and high recovery, ns
`define NFC_RESET_PULSE_NS  500
`define NFC_RESET_HIGH_NS   50
// Cycle counts, least times rounded up
`define NFC_CYC(ns) (((ns) + `NFC_CLK_PERIOD_NS - 1) / `NFC_CLK_PERIOD_NS)
// ==========================================
// Address fields, word mode
`define NFC_ADDR_W          21
`define NFC_DATA_W          16
`define NFC_BANK_MSB        20
`define NFC_BANK_LSB        18
`define NFC_SECT_MSB        20
`define NFC_SECT_LSB        15
// ==========================================
// Request opcodes
`define NFC_OP_READ         2'h0
`define NFC_OP_WRITE        2'h1
`define NFC_OP_RESET        2'h2
`define NFC_OP_IDLE         2'h3
`endif

// File: rtl/nfc_sync.v
// ==========================================
// Three-stage synchroniser; change taken when stages 2 and 3 agree
module nfc_sync
(
  // Clock and reset
  input  wire clock,
  input  wire rst_n,
  // Async level and filtered result
  input  wire din,
  output reg  dout_r
);
  reg s1_r;
  reg s2_r;
  reg s3_r;

  // Stage 1 feeds stage 2 only
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r   <= 1'b0;
      s2_r   <= 1'b0;
      s3_r   <= 1'b0;
      dout_r <= 1'b0;
    end
    else
    begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        dout_r <= s3_r;
    end
  end
endmodule

// File: rtl/nfc_host.v
`include "nfc_regs.vh"
module nfc_host
(
  // Clock and reset
  input  wire                    clock,
  input  wire                    arst_n,
  // User request
  input  wire                    req_valid,
  input  wire [1:0]              req_op,
  input  wire [`NFC_ADDR_W-1:0]  req_addr,
  input  wire [`NFC_DATA_W-1:0]  req_wdata,
  output wire                    req_ready,
  // User answer
  output reg                     rsp_valid_r,
  output reg  [`NFC_DATA_W-1:0]  rsp_rdata_r,
  output wire [1:0]              rsp_bank,
  output wire [5:0]              rsp_sector,
  // User accelerate request and busy view
  input  wire                    accel_req,
  output wire                    dev_busy,
  // Flash pins
  output reg  [`NFC_ADDR_W-1:0]  flash_addr_r,
  input  wire [`NFC_DATA_W-1:0]  data_lines_in,
  output reg  [`NFC_DATA_W-1:0]  data_lines_out_r,
  output reg                     data_lines_oe_r,
  output reg                     flash_sel_n_r,
  output reg                     write_n_r,
  output reg                     out_en_n_r,
  output reg                     flash_reset_n_r,
  output reg                     accel_high_r,
  input  wire                    ready_busy_out
);
  // ==========================================
  // Timing counts derived from clock rate
  localparam integer WR_PULSE_I = `NFC_CYC(`NFC_WR_PULSE_NS);
  localparam integer WR_RECOV_I = `NFC_CYC(`NFC_WR_RECOV_NS);
  localparam integer ADDR_I     = `NFC_CYC(`NFC_ADDR_ACCESS_NS + `NFC_OE_ACCESS_NS);
  localparam integer SEL_I      = `NFC_CYC(`NFC_SEL_ACCESS_NS + `NFC_OE_ACCESS_NS);
  localparam integer RST_LOW_I  = `NFC_CYC(`NFC_RESET_PULSE_NS);
  localparam integer RST_HIGH_I = `NFC_CYC(`NFC_RESET_HIGH_NS);
  localparam [7:0] WR_PULSE_CYC = WR_PULSE_I[7:0];
  localparam [7:0] WR_RECOV_CYC = WR_RECOV_I[7:0];
  localparam [7:0] ADDR_CYC     = ADDR_I[7:0];
  localparam [7:0] SEL_CYC      = SEL_I[7:0];
  localparam [7:0] RST_LOW_CYC  = RST_LOW_I[7:0];
  localparam [7:0] RST_HIGH_CYC = RST_HIGH_I[7:0];

  // States
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_WLOW  = 3'h1;
  localparam [2:0] ST_WREC  = 3'h2;
  localparam [2:0] ST_READ  = 3'h3;
  localparam [2:0] ST_RLOW  = 3'h4;
  localparam [2:0] ST_RHIGH = 3'h5;

  // ==========================================
  // Reset release through two flops
  reg rst_a_r;
  reg rst_n_r;
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_a_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_a_r <= 1'b1;
      rst_n_r <= rst_a_r;
    end
  end

  // Busy pin is asynchronous to us
  wire rb_sync;
  nfc_sync u_rb_sync
  (
    .clock  (clock),
    .rst_n  (rst_n_r),
    .din    (ready_busy_out),
    .dout_r (rb_sync)
  );
  assign dev_busy = ~rb_sync;

  // Address field decoding, used for answer and pin checks
  function [1:0] bank_of;
    input [`NFC_ADDR_W-1:0] a;
    reg   [2:0]             sel;
    begin
      // Banks are unequal: one eighth at each end, three eighths in between
      sel     = a[`NFC_BANK_MSB:`NFC_BANK_LSB];
      bank_of = (sel == 3'h7) ? 2'h0 : (sel[2] ? 2'h1 : ((sel == 3'h0) ? 2'h3 : 2'h2));
    end
  endfunction
  function [5:0] sector_of;
    input [`NFC_ADDR_W-1:0] a;
    begin
      sector_of = a[`NFC_SECT_MSB:`NFC_SECT_LSB];
    end
  endfunction
  assign rsp_bank   = bank_of(flash_addr_r);
  assign rsp_sector = sector_of(flash_addr_r);

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [7:0] cnt_r;
  reg [7:0] cnt_nxt;
  reg       cold_r;                 // Device in standby since last access
  reg       cold_nxt;
  reg [`NFC_ADDR_W-1:0] last_addr_r;
  reg [`NFC_ADDR_W-1:0] last_addr_nxt;

  assign req_ready = (state_r == ST_IDLE) && (req_op != `NFC_OP_IDLE);

  // ==========================================
  // Sequencer: one bus cycle per request; program flow is the user's
  always @*
  begin
    state_nxt     = state_r;
    cnt_nxt       = cnt_r;
    cold_nxt      = cold_r;
    last_addr_nxt = last_addr_r;
    case (state_r)
      ST_IDLE:
      begin
        if (req_valid && req_ready)
        begin
          last_addr_nxt = req_addr;
          case (req_op)
            `NFC_OP_WRITE:
            begin
              state_nxt = ST_WLOW;
              cnt_nxt   = WR_PULSE_CYC;
            end
            `NFC_OP_READ:
            begin
              state_nxt = ST_READ;
              // Standby exit needs full select access
              cnt_nxt   = cold_r ? SEL_CYC : ADDR_CYC;
            end
            default:
            begin
              state_nxt = ST_RLOW;
              cnt_nxt   = RST_LOW_CYC;
            end
          endcase
        end
      end
      ST_WLOW:
      begin
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r == 8'h01)
        begin
          state_nxt = ST_WREC;
          cnt_nxt   = WR_RECOV_CYC;
        end
      end
      ST_WREC, ST_READ:
      begin
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r == 8'h01)
        begin
          state_nxt = ST_IDLE;
          cold_nxt  = 1'b1;                   // Select drops, standby next
        end
      end
      ST_RLOW:
      begin
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r == 8'h01)
        begin
          state_nxt = ST_RHIGH;
          cnt_nxt   = RST_HIGH_CYC;
        end
      end
      ST_RHIGH:
      begin
        if (cnt_r != 8'h00)
          cnt_nxt = cnt_r - 8'h01;
        // Busy pin must also clear before reads resume
        if (cnt_r <= 8'h01 && rb_sync)
        begin
          cnt_nxt   = 8'h00;
          state_nxt = ST_IDLE;
          cold_nxt  = 1'b1;
        end
      end
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // ==========================================
  // State registers and pin drive; all pins from flops
  always @(posedge clock or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      state_r          <= ST_IDLE;
      cnt_r            <= 8'h00;
      cold_r           <= 1'b1;
      last_addr_r      <= {`NFC_ADDR_W{1'b0}};
      flash_addr_r     <= {`NFC_ADDR_W{1'b0}};
      data_lines_out_r <= {`NFC_DATA_W{1'b0}};
      data_lines_oe_r  <= 1'b0;
      flash_sel_n_r    <= 1'b1;
      write_n_r        <= 1'b1;
      out_en_n_r       <= 1'b1;
      flash_reset_n_r  <= 1'b1;
      accel_high_r     <= 1'b0;
      rsp_valid_r      <= 1'b0;
      rsp_rdata_r      <= {`NFC_DATA_W{1'b0}};
    end
    else
    begin
      state_r     <= state_nxt;
      cnt_r       <= cnt_nxt;
      cold_r      <= (state_r == ST_IDLE && req_valid && req_ready) ? 1'b0 : cold_nxt;
      last_addr_r <= last_addr_nxt;
      rsp_valid_r <= 1'b0;
      // Accelerate only when the user asks; pin always driven
      accel_high_r <= accel_req;
      if (state_r == ST_IDLE && req_valid && req_ready)
      begin
        flash_addr_r <= req_addr;
        case (req_op)
          `NFC_OP_WRITE:
          begin
            flash_sel_n_r    <= 1'b0;
            write_n_r        <= 1'b0;
            out_en_n_r       <= 1'b1;
            data_lines_out_r <= req_wdata;
            data_lines_oe_r  <= 1'b1;
          end
          `NFC_OP_READ:
          begin
            flash_sel_n_r <= 1'b0;
            out_en_n_r    <= 1'b0;
          end
          default:
            flash_reset_n_r <= 1'b0;
        endcase
      end
      else if (state_r == ST_WLOW && cnt_r == 8'h01)
      begin
        // Device latches data on the rising write edge
        write_n_r     <= 1'b1;
        flash_sel_n_r <= 1'b1;
      end
      else if (state_r == ST_WREC && cnt_r == 8'h01)
      begin
        data_lines_oe_r <= 1'b0;
        rsp_valid_r     <= 1'b1;
      end
      else if (state_r == ST_READ && cnt_r == 8'h01)
      begin
        rsp_rdata_r   <= data_lines_in;
        rsp_valid_r   <= 1'b1;
        out_en_n_r    <= 1'b1;
        flash_sel_n_r <= 1'b1;
      end
      else if (state_r == ST_RLOW && cnt_r == 8'h01)
        flash_reset_n_r <= 1'b1;
      else if (state_r == ST_RHIGH && state_nxt == ST_IDLE)
        rsp_valid_r <= 1'b1;
    end
  end
endmodule

// File: verif/nfc_host_props.sv
module nfc_host_props
(
  // Clock and reset
  input logic        clock,
  input logic        arst_n,
  // Watched ports
  input logic        accel_req,
  input logic        rsp_valid_r,
  input logic [5:0]  rsp_sector,
  input logic [20:0] flash_addr_r,
  input logic        data_lines_oe_r,
  input logic        flash_sel_n_r,
  input logic        write_n_r,
  input logic        out_en_n_r,
  input logic        flash_reset_n_r,
  input logic        accel_high_r
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // Strobe shapes, counted in host cycles; then accelerate pin and sector map
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  a_write_qualify: assert property (
    !write_n_r |-> !flash_sel_n_r && out_en_n_r && data_lines_oe_r) else $error("bad write");
  a_write_width: assert property (
    $fell(write_n_r) |-> !write_n_r [*4] ##1 write_n_r) else $error("bad write width");
  a_read_access: assert property (
    $fell(out_en_n_r) |-> ##9 !out_en_n_r ##1 out_en_n_r && rsp_valid_r) else $error("bad read");
  a_read_float: assert property (
    !out_en_n_r |-> !data_lines_oe_r) else $error("host drives during read");
  a_reset_width: assert property (
    $fell(flash_reset_n_r) |-> ##49 !flash_reset_n_r ##1 flash_reset_n_r) else $error("bad reset");
  a_reset_recover: assert property (
    $rose(flash_reset_n_r) |-> !rsp_valid_r [*5]) else $error("reset recovery short");
  a_accel_on: assert property (
    $rose(accel_req) |=> accel_high_r) else $error("accel not applied");
  a_accel_off: assert property (
    $fell(accel_req) |=> !accel_high_r) else $error("accel not removed");
  a_sector_map: assert property (
    !flash_sel_n_r |-> rsp_sector == flash_addr_r[20:15]) else $error("bad sector");
endmodule
bind nfc_host nfc_host_props nfc_host_props_inst (.clock, .arst_n, .accel_req, .rsp_valid_r,
  .rsp_sector, .flash_addr_r, .data_lines_oe_r, .flash_sel_n_r, .write_n_r, .out_en_n_r,
  .flash_reset_n_r, .accel_high_r);

// File: verif/nfc_flash_model.sv
module nfc_flash_model
#(
  parameter        ACCESS_NS = 70,
  parameter        BUSY_NS  = 300,
  parameter        READY_NS = 200,
  parameter [15:0] ID_WORD  = 16'h5a3c // Arbitrary value
)
(
  // Flash pins
  input  logic [20:0] addr,
  input  logic [15:0] din,
  output logic [15:0] dq,
  input  logic        sel_n,
  input  logic        we_n,
  input  logic        oe_n,
  input  logic        rst_n,
  input  logic        accel,
  output logic        ready_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [logic [20:0]];
  logic        id_mode = 1'b0;
  logic        wr_pend = 1'b0;
  logic [15:0] noise = 16'h0;
  realtime     t_on = 0.0;
  realtime     busy_end = 0.0;
  // ====
  // Write window open while both strobes low
  always @*
    if (!we_n && !sel_n && oe_n && rst_n) wr_pend = 1'b1;
  // Whichever strobe rises first ends the write
  always @(posedge we_n or posedge sel_n)
    if (wr_pend)
    begin
      wr_pend = 1'b0;
      if (din == 16'h0090) id_mode = 1'b1;
      else if (din == 16'h00f0) id_mode = 1'b0;
      else
      begin
        mem[addr] = din;
        busy_end = $realtime + (accel ? BUSY_NS / 2 : BUSY_NS);
      end
    end
  // Reset aborts; idle reset leaves busy high
  always @(negedge rst_n)
  begin
    id_mode = 1'b0;
    if ($realtime < busy_end) busy_end = $realtime + READY_NS;
  end
  // Access time counted from the later strobe
  always @(negedge sel_n or negedge oe_n) t_on = $realtime;
  // Off clock edges; released pins churn so no stale value passes
  always
  begin
    #0.5;
    noise = noise + 16'h1357;
    ready_busy = $realtime >= busy_end;
    if (!sel_n && !oe_n && rst_n && $realtime - t_on >= ACCESS_NS)
      dq = id_mode ? ID_WORD : (mem.exists(addr) ? mem[addr] : 16'hffff);
    else
      dq = noise;
    #0.5;
  end
endmodule

// File: verif/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [15:0] ID_W = 16'h5a3c; // Arbitrary value
  logic        clock = 1'b0, arst_n = 1'b0, req_valid = 1'b0, accel_req = 1'b0;
  logic [1:0]  req_op = 2'h3, rsp_bank;
  logic [20:0] req_addr = 21'h0, flash_addr_r, aa [4];
  logic [15:0] req_wdata = 16'h0, rsp_rdata_r, data_lines_in, data_lines_out_r, dd [4];
  logic [5:0]  rsp_sector;
  logic        req_ready, rsp_valid_r, dev_busy, data_lines_oe_r, flash_sel_n_r, write_n_r;
  logic        out_en_n_r, flash_reset_n_r, accel_high_r, ready_busy_out;
  logic        rdq [$];
  logic [15:0] exq [$];
  int          bad_count = 0, compares = 0;
  nfc_host nfc_host_inst (.clock, .arst_n, .req_valid, .req_op, .req_addr, .req_wdata,
    .req_ready, .rsp_valid_r, .rsp_rdata_r, .rsp_bank, .rsp_sector, .accel_req, .dev_busy,
    .flash_addr_r, .data_lines_in, .data_lines_out_r, .data_lines_oe_r, .flash_sel_n_r,
    .write_n_r, .out_en_n_r, .flash_reset_n_r, .accel_high_r, .ready_busy_out);
  nfc_flash_model #(.ID_WORD(ID_W)) nfc_flash_model_inst (.addr(flash_addr_r),
    .din(data_lines_out_r), .dq(data_lines_in), .sel_n(flash_sel_n_r), .we_n(write_n_r),
    .oe_n(out_en_n_r), .rst_n(flash_reset_n_r), .accel(accel_high_r),
    .ready_busy(ready_busy_out));
  // ====
  // Clock
  always #5 clock = ~clock;
  task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task report_and_stop;
    if (bad_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One request; held until taken, expectation queued
  task go(input logic [1:0] o, input logic [20:0] a, input logic [15:0] d, e);
    int n;
    n = 0;
    @(posedge clock);
    req_valid <= 1'b1;
    req_op <= o;
    req_addr <= a;
    req_wdata <= d;
    do begin @(posedge clock); n++; end while (req_ready !== 1'b1 && n < 300);
    if (n >= 300) bad_count++;
    req_valid <= 1'b0;
    rdq.push_back(o == 2'h0);
    exq.push_back(e);
  endtask
  // Read answers checked against oldest note; write and reset answers only dequeued
  always @(posedge clock)
    if (rsp_valid_r === 1'b1)
    begin
      if (rdq.size() == 0) check("rsp", 16'h1, 16'h0);
      else if (rdq.pop_front()) check("rdata", rsp_rdata_r, exq.pop_front());
      else void'(exq.pop_front());
    end
  // Hang guard
  initial
  begin
    #200000;
    bad_count++;
    report_and_stop;
  end
  // ====
  // Main sequence
  initial
  begin
    void'($urandom(33));
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    repeat (8) @(posedge clock);
    go(2'h1, 21'h000555, 16'h0090, 16'h0);
    go(2'h0, 21'h000000, 16'h0, ID_W);
    go(2'h1, 21'h000555, 16'h00f0, 16'h0);
    // Idle opcode must never be taken, even once the sequencer is idle
    @(posedge clock);
    req_op <= 2'h3;
    req_valid <= 1'b1;
    repeat (12) @(posedge clock);
    check("idle_ready", {15'h0, req_ready}, 16'h0);
    req_valid <= 1'b0;
    for (int b = 0; b < 4; b++)
    begin
      // One address in each of the four banks
      aa[b] = {((b == 0) ? 3'h0 : (b == 1) ? 3'h1 : (b == 2) ? 3'h4 : 3'h7), 18'($urandom)};
      dd[b] = 16'($urandom) | 16'h0100;
      go(2'h1, aa[b], dd[b], 16'h0);
      repeat (12) @(posedge clock);
      check("busy", {15'h0, dev_busy}, 16'h1);
      check("bank", {14'h0, rsp_bank}, 16'(3 - b));
      check("sector", {10'h0, rsp_sector}, {10'h0, aa[b][20:15]});
      if (b > 0) go(2'h0, aa[b-1], 16'h0, dd[b-1]);
    end
    accel_req <= 1'b1;
    go(2'h1, 21'h000555, 16'h00a0, 16'h0);
    go(2'h1, 21'h1f8000, 16'h1234, 16'h0);
    check("accel", {15'h0, accel_high_r}, 16'h1);
    go(2'h0, 21'h1f8000, 16'h0, 16'h1234);
    accel_req <= 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      go(2'h1, 21'h000555, k ? 16'h0090 : dd[3], 16'h0);
      go(2'h2, 21'h0, 16'h0, 16'h0);
      go(2'h0, 21'h000004, 16'h0, 16'hffff);
      check("ready", {15'h0, dev_busy}, 16'h0);
      go(2'h0, aa[0], 16'h0, dd[0]);
    end
    repeat (20) @(posedge clock);
    check("pending", 16'(rdq.size()), 16'h0);
    report_and_stop;
  end
endmodule
